// file: shared/usb_bd_irq_consts.vh
`ifndef USB_BD_IRQ_CONSTS_VH
`define USB_BD_IRQ_CONSTS_VH

// clock and timing
`define CLK_PERIOD_NS 50
`define IDLE_TIME_NS 3000000

// apb map, byte addresses
`define ADDR_W 11
`define ADDR_BD_LAST 11'h3FC
`define ADDR_FLAGS 11'h400
`define ADDR_ENABLES 11'h404
`define ADDR_ERR_FLAGS 11'h408
`define ADDR_ERR_ENABLES 11'h40C
`define ADDR_CONFIG 11'h410
`define ADDR_TRN_STATUS 11'h414
`define ADDR_DEV_ADDR 11'h418

// double-buffering modes
`define MODE_NONE 2'h0
`define MODE_EP0_OUT 2'h1
`define MODE_ALL 2'h2
`define MODE_ALL_BUT_EP0 2'h3

// top-level flag bit positions
`define FLG_RESET 0
`define FLG_ERROR 1
`define FLG_ACTIVITY 2
`define FLG_TRN 3
`define FLG_IDLE 4
`define FLG_STALL 5
`define FLG_SOF 6
`define FLAGS_WMASK 8'h7D

// config register fields
`define CFG_MODE_LO 0
`define CFG_ENABLE 2
`define CFG_PTR_RESET 3

// descriptor status fields
`define ST_OWN 7
`define ST_TOGGLE 6
`define ST_TOGGLE_CHECK 3
`define ERR_MASK 8'h9F

// line levels at bus idle, full-speed J state
`define DP_IDLE 1'b1
`define DM_IDLE 1'b0

// reset values
`define ZERO8 8'h00
`define ZERO32 32'h0000_0000

`endif

// file: src/usb_bd_irq.v
// Functional notes
// - no double buffering: OUT 2n, IN 2n+1
// - ep0 OUT paired 0/1; others shifted one
// - all double: OUT 4n/4n+1, IN 4n+2/4n+3
// - all but ep0: ep0 single, others paired
// - 64 four-byte descriptors, no reset value
// - engine writes token id into status 5:2
// - expected toggle ignored unless check enabled
// - all sources form one core request
// - error level raises summary error flag
// - status flags ORed into core flag
// - engine-set flags stay until written zero
// - firmware ones set flags, except summary error
// - start-of-frame sets bit 6
// - stall handshake sent sets bit 5
// - idle for 3 ms sets bit 4
// - transaction done sets bit 3, status readable
// - clearing done flag advances status fifo
// - line activity sets bit 2
// - bit 1 read-only, enabled errors only
// - bus reset sets bit 0, zeroes address
// - enables gate only the request, not flags
// - enabled error flags ORed into summary
// - even/odd pointer per endpoint direction toggles on double-buffered completion
`timescale 1ns/1ps
`default_nettype none
`include "usb_bd_irq_consts.vh"

module usb_bd_irq #(
	parameter IDLE_CYCLES = `IDLE_TIME_NS / `CLK_PERIOD_NS,
	parameter FIFO_DEPTH_LOG2 = 2
) (
	input wire core_clk_in,
	input wire rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [`ADDR_W-1:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	input wire dplus_in,
	input wire dminus_in,
	input wire sof_token_in,
	input wire stall_sent_in,
	input wire bus_reset_in,
	input wire [7:0] error_events_in,
	input wire [3:0] map_ep_in,
	input wire map_dir_in,
	output reg [5:0] map_slot_out,
	output reg map_odd_out,
	input wire [5:0] engine_bd_index_in,
	input wire engine_rx_toggle_in,
	output reg [31:0] engine_desc_out,
	output reg toggle_ok_out,
	input wire engine_done_in,
	input wire [3:0] engine_token_id_in,
	input wire [9:0] engine_count_in,
	input wire [3:0] trn_ep_in,
	input wire trn_dir_in,
	output reg [6:0] device_bus_address_out,
	output reg usb_core_irq_flag_out
);
	localparam FIFO_DEPTH = 1 << FIFO_DEPTH_LOG2;

	// descriptor storage, four bytes per slot, no reset
	reg [7:0] bd_mem [0:255];
	reg [7:0] flags;
	reg [7:0] enables;
	reg [7:0] err_flags;
	reg [7:0] err_enables;
	reg [1:0] mode;
	reg module_enable;
	reg enable_d;
	reg [31:0] pp_ptr;
	reg [5:0] fifo_mem [0:FIFO_DEPTH-1];
	reg [FIFO_DEPTH_LOG2-1:0] rd_ptr;
	reg [FIFO_DEPTH_LOG2-1:0] wr_ptr;
	reg [FIFO_DEPTH_LOG2:0] fifo_count;
	reg [1:0] dp_sync;
	reg [1:0] dm_sync;
	reg [1:0] line_prev;
	reg [15:0] idle_count;
	reg idle_seen;
	reg activity_armed;

	// slot for endpoint, direction and even/odd choice
	function [5:0] slot_of;
		input [1:0] m;
		input [3:0] ep;
		input dir;
		input odd;
		reg [5:0] e;
		begin
			e = {2'b00, ep};
			case (m)
				`MODE_NONE: slot_of = {ep, 1'b0} + {5'b00000, dir};
				`MODE_EP0_OUT:
				begin
					if (ep == 4'h0 && !dir)
						slot_of = {5'b00000, odd};
					else
						slot_of = {ep, 1'b0} + {5'b00000, dir} + 6'h01;
				end
				`MODE_ALL: slot_of = {ep, dir, odd};
				`MODE_ALL_BUT_EP0:
				begin
					if (ep == 4'h0)
						slot_of = {5'b00000, dir};
					else
						slot_of = (e << 2) - 6'h02 + {4'h0, dir, odd};
				end
				default: slot_of = 6'h00;
			endcase
		end
	endfunction

	// whether an endpoint direction has two descriptors
	function is_double;
		input [1:0] m;
		input [3:0] ep;
		input dir;
		begin
			case (m)
				`MODE_EP0_OUT: is_double = (ep == 4'h0) && !dir;
				`MODE_ALL: is_double = 1'b1;
				`MODE_ALL_BUT_EP0: is_double = (ep != 4'h0);
				default: is_double = 1'b0;
			endcase
		end
	endfunction

	// apb decode
	wire setup_phase = psel_in && !penable_in;
	wire wr_access = psel_in && penable_in && pready_out && pwrite_in;
	wire is_bd = (paddr_in <= `ADDR_BD_LAST);
	wire [7:0] bd_byte = paddr_in[9:2];
	wire mapped = is_bd || paddr_in == `ADDR_FLAGS || paddr_in == `ADDR_ENABLES ||
		paddr_in == `ADDR_ERR_FLAGS || paddr_in == `ADDR_ERR_ENABLES ||
		paddr_in == `ADDR_CONFIG || paddr_in == `ADDR_TRN_STATUS || paddr_in == `ADDR_DEV_ADDR;
	wire wr_flags = wr_access && paddr_in == `ADDR_FLAGS;
	wire wr_errs = wr_access && paddr_in == `ADDR_ERR_FLAGS;
	wire wr_cfg = wr_access && paddr_in == `ADDR_CONFIG;

	// summary error from enabled error flags only
	wire summary_error = |(err_flags & err_enables);

	// line activity and idle
	wire [1:0] line_now = {dp_sync[1], dm_sync[1]};
	wire line_change = line_now != line_prev;
	wire idle_event = !idle_seen && !line_change && idle_count == IDLE_CYCLES[15:0] - 16'h0001;
	wire activity_event = line_change && activity_armed;

	// status fifo, one entry per completed token
	wire fifo_pop = wr_flags && flags[`FLG_TRN] && !pwdata_in[`FLG_TRN] && fifo_count != 0;
	wire fifo_push = engine_done_in && fifo_count != FIFO_DEPTH[FIFO_DEPTH_LOG2:0];
	wire trn_set = fifo_push || (fifo_pop && fifo_count > 1);
	wire done_odd = pp_ptr[{trn_ep_in, trn_dir_in}];
	wire [5:0] done_slot = slot_of(mode, trn_ep_in, trn_dir_in, done_odd);

	// hardware set events, one per flag
	reg [7:0] hw_set;
	always @*
	begin
		hw_set = `ZERO8;
		hw_set[`FLG_SOF] = sof_token_in;
		hw_set[`FLG_STALL] = stall_sent_in;
		hw_set[`FLG_IDLE] = idle_event;
		hw_set[`FLG_TRN] = trn_set;
		hw_set[`FLG_ACTIVITY] = activity_event;
		hw_set[`FLG_RESET] = bus_reset_in;
	end

	// next flag value: written bits, then hardware sets win
	wire [7:0] flags_kept = wr_flags ? (pwdata_in[7:0] & `FLAGS_WMASK) : (flags & `FLAGS_WMASK);
	wire [7:0] next_flags = (flags_kept | hw_set) & `FLAGS_WMASK;
	wire [7:0] next_err = ((wr_errs ? pwdata_in[7:0] & err_flags : err_flags) | error_events_in) & `ERR_MASK;

	// read mux for the register in setup
	reg [7:0] rd_byte;
	always @*
	begin
		rd_byte = `ZERO8;
		if (is_bd)
			rd_byte = bd_mem[bd_byte];
		else if (paddr_in == `ADDR_FLAGS)
			rd_byte = {1'b0, flags[6:2], summary_error, flags[0]};
		else if (paddr_in == `ADDR_ENABLES)
			rd_byte = enables;
		else if (paddr_in == `ADDR_ERR_FLAGS)
			rd_byte = err_flags;
		else if (paddr_in == `ADDR_ERR_ENABLES)
			rd_byte = err_enables;
		else if (paddr_in == `ADDR_CONFIG)
			rd_byte = {5'b00000, module_enable, mode};
		else if (paddr_in == `ADDR_TRN_STATUS)
			rd_byte = {1'b0, fifo_count != 0, fifo_mem[rd_ptr]};
		else if (paddr_in == `ADDR_DEV_ADDR)
			rd_byte = {1'b0, device_bus_address_out};
	end

	// apb answer one cycle after setup
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= `ZERO32;
		end
		else
		begin
			pready_out <= setup_phase;
			pslverr_out <= setup_phase && !mapped;
			if (setup_phase)
				prdata_out <= {24'h00_0000, rd_byte};
		end
	end

	// descriptor writes from firmware and from the engine
	always @(posedge core_clk_in)
	begin
		if (wr_access && is_bd)
			bd_mem[bd_byte] <= pwdata_in[7:0];
		if (engine_done_in)
		begin
			// own cleared, bit 6 untouched, token id over 5:2
			bd_mem[{done_slot, 2'b00}] <= {1'b0, bd_mem[{done_slot, 2'b00}][6], engine_token_id_in,
				engine_count_in[9:8]};
			bd_mem[{done_slot, 2'b01}] <= engine_count_in[7:0];
		end
	end

	// flag, enable and config registers
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			flags <= `ZERO8;
			err_flags <= `ZERO8;
			enables <= `ZERO8;
			err_enables <= `ZERO8;
			mode <= `MODE_NONE;
			module_enable <= 1'b0;
			device_bus_address_out <= 7'h00;
		end
		else
		begin
			flags <= next_flags;
			err_flags <= next_err;
			if (wr_access && paddr_in == `ADDR_ENABLES)
				enables <= pwdata_in[7:0] & 8'h7F;
			if (wr_access && paddr_in == `ADDR_ERR_ENABLES)
				err_enables <= pwdata_in[7:0] & `ERR_MASK;
			if (wr_cfg)
			begin
				mode <= pwdata_in[`CFG_MODE_LO+1:`CFG_MODE_LO];
				module_enable <= pwdata_in[`CFG_ENABLE];
			end
			if (bus_reset_in)
				device_bus_address_out <= 7'h00;
			else if (wr_access && paddr_in == `ADDR_DEV_ADDR)
				device_bus_address_out <= pwdata_in[6:0];
		end
	end

	// even/odd pointers, cleared on enable or pointer reset
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pp_ptr <= `ZERO32;
			enable_d <= 1'b0;
		end
		else
		begin
			enable_d <= module_enable;
			if ((module_enable && !enable_d) || (wr_cfg && pwdata_in[`CFG_PTR_RESET]))
				pp_ptr <= `ZERO32;
			else if (engine_done_in && is_double(mode, trn_ep_in, trn_dir_in))
				pp_ptr[{trn_ep_in, trn_dir_in}] <= !done_odd;
		end
	end

	// transaction status fifo pointers
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rd_ptr <= {FIFO_DEPTH_LOG2{1'b0}};
			wr_ptr <= {FIFO_DEPTH_LOG2{1'b0}};
			fifo_count <= {(FIFO_DEPTH_LOG2+1){1'b0}};
		end
		else
		begin
			if (fifo_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (fifo_pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (fifo_push && !fifo_pop)
				fifo_count <= fifo_count + 1'b1;
			else if (fifo_pop && !fifo_push)
				fifo_count <= fifo_count - 1'b1;
		end
	end

	// fifo entry: endpoint, direction, even/odd used
	always @(posedge core_clk_in)
	begin
		if (fifo_push)
			fifo_mem[wr_ptr] <= {trn_ep_in, trn_dir_in, done_odd};
	end

	// line synchronisers, idle timer and activity arming
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			dp_sync <= {2{`DP_IDLE}}; // idle level, no false edge after reset
			dm_sync <= {2{`DM_IDLE}};
			line_prev <= {`DP_IDLE, `DM_IDLE};
			idle_count <= 16'h0000;
			idle_seen <= 1'b0;
			activity_armed <= 1'b1;
		end
		else
		begin
			dp_sync <= {dp_sync[0], dplus_in};
			dm_sync <= {dm_sync[0], dminus_in};
			line_prev <= line_now;
			if (line_change)
			begin
				idle_count <= 16'h0000;
				idle_seen <= 1'b0;
			end
			else if (!idle_seen)
			begin
				idle_count <= idle_count + 16'h0001;
				if (idle_event)
					idle_seen <= 1'b1;
			end
			// one activity event per idle period
			if (activity_event)
				activity_armed <= 1'b0;
			else if (idle_event)
				activity_armed <= 1'b1;
		end
	end

	// mapping and descriptor view toward the engine
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			map_slot_out <= 6'h00;
			map_odd_out <= 1'b0;
			engine_desc_out <= `ZERO32;
			toggle_ok_out <= 1'b0;
		end
		else
		begin
			map_odd_out <= is_double(mode, map_ep_in, map_dir_in) && pp_ptr[{map_ep_in, map_dir_in}];
			map_slot_out <= slot_of(mode, map_ep_in, map_dir_in, pp_ptr[{map_ep_in, map_dir_in}]);
			engine_desc_out <= {bd_mem[{engine_bd_index_in, 2'b11}], bd_mem[{engine_bd_index_in, 2'b10}],
				bd_mem[{engine_bd_index_in, 2'b01}], bd_mem[{engine_bd_index_in, 2'b00}]};
			toggle_ok_out <= !bd_mem[{engine_bd_index_in, 2'b00}][`ST_TOGGLE_CHECK] ||
				(bd_mem[{engine_bd_index_in, 2'b00}][`ST_TOGGLE] == engine_rx_toggle_in);
		end
	end

	// single request toward the core from enabled flags
	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
			usb_core_irq_flag_out <= 1'b0;
		else
			usb_core_irq_flag_out <= |({flags[6:2], summary_error, flags[0]} & enables[6:0]);
	end
endmodule // usb_bd_irq
`default_nettype wire

// file: tb/usb_bd_irq_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_bd_irq_consts.vh"
module usb_bd_irq_properties (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [`ADDR_W-1:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic bus_reset_in,
	input wire logic [6:0] device_bus_address_out,
	input wire logic usb_core_irq_flag_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);
	// completed access cycle
	wire acc = psel_in && penable_in && pready_out;
	AST_READY_NEXT: assert property (psel_in && !penable_in |=> pready_out)
		else $error("ready missing after setup");
	AST_READY_CAUSE: assert property (pready_out |-> $past(psel_in && !penable_in))
		else $error("ready without setup");
	AST_SLVERR_UNMAPPED: assert property (acc && paddr_in > `ADDR_DEV_ADDR |-> pslverr_out)
		else $error("unmapped access not refused");
	AST_SLVERR_MAPPED: assert property (acc && paddr_in <= `ADDR_DEV_ADDR && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
		else $error("mapped access refused");
	AST_RDATA_HIGH: assert property (acc && !pwrite_in |-> prdata_out[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	AST_FLAG_BIT7: assert property (acc && !pwrite_in && paddr_in == `ADDR_FLAGS |-> !prdata_out[7])
		else $error("flag bit 7 reads one");
	AST_ADDR_ZERO: assert property (bus_reset_in |=> device_bus_address_out == 7'h00)
		else $error("address not zeroed by bus reset");
	AST_ADDR_HOLD: assert property (!bus_reset_in && !(acc && pwrite_in && paddr_in == `ADDR_DEV_ADDR)
		|=> $stable(device_bus_address_out))
		else $error("address changed without cause");
	// main scenarios
	cover property (bus_reset_in);
	cover property ($rose(usb_core_irq_flag_out));
	cover property (acc && pslverr_out);
endmodule // usb_bd_irq_properties
bind usb_bd_irq usb_bd_irq_properties chk_u (.core_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
	.paddr_in, .prdata_out, .pready_out, .pslverr_out, .bus_reset_in, .device_bus_address_out,
	.usb_core_irq_flag_out);
`default_nettype wire

// file: tb/usb_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_line_model (
	input wire logic clk_in,
	input wire logic active_in,
	output logic dplus_out = 1'b1,
	output logic dminus_out = 1'b0
);
	// differential toggling while active, idle J state otherwise
	always @(posedge clk_in)
	begin
		if (active_in)
		begin
			dplus_out <= ~dplus_out;
			dminus_out <= dplus_out;
		end
		else
		begin
			dplus_out <= 1'b1;
			dminus_out <= 1'b0;
		end
	end
endmodule // usb_line_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_bd_irq_consts.vh"
module testbench;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, line_on = 0, done = 0, dir = 0, rx = 0;
	logic pready, pslverr, dp, dm, odd, tog_ok, irq, rerr;
	logic [10:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdv, s, desc, seed = 32'h0001_2E66;
	logic [2:0] evt = 0;
	logic [7:0] errs = 0, eb;
	logic [3:0] ep = 0, tok = 0;
	logic [9:0] cnt = 0;
	logic [5:0] bdi = 0, slot;
	logic [6:0] dev_addr;
	int num_errors = 0, tests_run = 0;
	usb_bd_irq #(.IDLE_CYCLES(20)) dut_u (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .dplus_in(dp), .dminus_in(dm), .sof_token_in(evt[2]), .stall_sent_in(evt[1]),
		.bus_reset_in(evt[0]), .error_events_in(errs), .map_ep_in(ep), .map_dir_in(dir), .map_slot_out(slot),
		.map_odd_out(odd), .engine_bd_index_in(bdi), .engine_rx_toggle_in(rx), .engine_desc_out(desc),
		.toggle_ok_out(tog_ok), .engine_done_in(done), .engine_token_id_in(tok), .engine_count_in(cnt),
		.trn_ep_in(ep), .trn_dir_in(dir), .device_bus_address_out(dev_addr), .usb_core_irq_flag_out(irq));
	usb_line_model line_u (.clk_in(clk), .active_in(line_on), .dplus_out(dp), .dminus_out(dm));
	// 20 MHz clock
	initial forever #25 clk = ~clk;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// slot expected for mode, endpoint, direction with even pointer
	function automatic int exp_slot(input int m, input int e, input int d);
		case (m)
			0: return 2 * e + d;
			1: return (e == 0) ? 2 * d : 2 * e + 1 + d;
			2: return 4 * e + 2 * d;
			default: return (e == 0) ? d : 4 * e - 2 + 2 * d;
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, held until ready is sampled at a rising edge
	task automatic apb(input logic w, input logic [10:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rdv = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [10:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task automatic chk_rd(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e);
		apb(0, a, 0);
		chk(rdv & m, e);
	endtask
	task automatic pulse(input logic [2:0] v);
		@(posedge clk);
		evt <= v;
		@(posedge clk);
		evt <= 0;
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
	// main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 0;
		repeat (40) @(posedge clk);
		chk_rd(`ADDR_FLAGS, 8'h14, 8'h10);
		wr(`ADDR_ENABLES, 32'h0000_0004);
		line_on <= 1;
		repeat (10) @(posedge clk);
		chk_rd(`ADDR_FLAGS, 8'h14, 8'h14);
		chk(irq, 1);
		wr(`ADDR_FLAGS, 0);
		for (int m = 0; m < 4; m++)
		begin
			wr(`ADDR_CONFIG, m + 12);
			for (int e = 0; e < 32; e++)
			begin
				@(posedge clk);
				ep <= e[4:1];
				dir <= e[0];
				@(posedge clk);
				@(negedge clk);
				chk(slot, exp_slot(m, e[4:1], e[0]));
			end
		end
		// random descriptor bytes
		for (int i = 0; i < 8; i++)
		begin
			s = xs();
			wr({1'b0, s[7:0], 2'b00}, {24'h00_0000, s[15:8]});
			chk_rd({1'b0, s[7:0], 2'b00}, 8'hFF, s[15:8]);
		end
		// completion on endpoint 0 out, all double-buffered
		wr(`ADDR_CONFIG, 32'h0000_000E);
		wr(11'h000, 32'h0000_0048);
		@(posedge clk);
		ep <= 0;
		dir <= 0;
		tok <= 4'hD;
		cnt <= 10'h2A5;
		done <= 1;
		@(posedge clk);
		done <= 0;
		chk_rd(11'h000, 8'hFF, 8'h76);
		chk_rd(11'h004, 8'hFF, 8'hA5);
		chk_rd(`ADDR_FLAGS, 8'h08, 8'h08);
		chk_rd(`ADDR_TRN_STATUS, 8'h7F, 8'h40);
		@(negedge clk);
		chk({odd, slot}, 7'h41);
		wr(`ADDR_FLAGS, 0);
		chk_rd(`ADDR_TRN_STATUS, 8'h40, 8'h00);
		// toggle check on slot 5
		for (int t = 0; t < 3; t++)
		begin
			wr(11'h050, (t == 2) ? 32'h0000_0040 : 32'h0000_0048);
			@(posedge clk);
			rx <= t[0];
			bdi <= 6'h05;
			@(posedge clk);
			@(negedge clk);
			chk(tog_ok, t != 0);
			chk(desc[7:0], (t == 2) ? 8'h40 : 8'h48);
		end
		wr(`ADDR_ENABLES, 32'h0000_0040);
		pulse(3'b100);
		chk_rd(`ADDR_FLAGS, 8'h40, 8'h40);
		chk(irq, 1);
		pulse(3'b010);
		chk_rd(`ADDR_FLAGS, 8'h20, 8'h20);
		wr(`ADDR_FLAGS, 0);
		chk_rd(`ADDR_FLAGS, 8'hFF, 8'h00);
		wr(`ADDR_ENABLES, 0);
		wr(`ADDR_FLAGS, 32'h0000_00FF);
		chk_rd(`ADDR_FLAGS, 8'hFF, 8'h7D);
		chk(irq, 0);
		wr(`ADDR_FLAGS, 0);
		wr(`ADDR_DEV_ADDR, 32'h0000_0055);
		pulse(3'b001);
		@(negedge clk);
		chk(dev_addr, 0);
		chk_rd(`ADDR_FLAGS, 8'h01, 8'h01);
		// random enabled error sources
		s = xs();
		eb = s[7:0] & 8'h9F | 8'h01;
		wr(`ADDR_ERR_ENABLES, {24'h00_0000, eb});
		@(posedge clk);
		errs <= eb;
		@(posedge clk);
		errs <= 0;
		chk_rd(`ADDR_ERR_FLAGS, 8'hFF, eb);
		chk_rd(`ADDR_FLAGS, 8'h02, 8'h02);
		wr(`ADDR_FLAGS, 0);
		chk_rd(`ADDR_FLAGS, 8'h02, 8'h02);
		wr(`ADDR_ERR_ENABLES, 0);
		chk_rd(`ADDR_FLAGS, 8'h02, 8'h00);
		chk_rd(11'h41C, 8'hFF, 8'h00);
		chk(rerr, 1);
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
